/* sse_exec.sv */
// Execution logic for the power-down and the two subtract instructions.
// Assumes the instruction word is stable for a whole four-phase cycle and that
// file read data for the addressed register is valid from Q2 onward.
//
// Summary of operation
// RQ1: Decode power-down opcode 00 0000 0110 0011.
// RQ2: Power-down clears sleep flag, sets time-out flag.
// RQ3: Power-down leaves carry, nibble, zero flags untouched.
// RQ4: Power-down clears watchdog counter and prescaler.
// RQ5: Enter sleep with oscillator halted.
// RQ6: Power-down: Q1 decode, Q2 idle, Q3 sleep.
// RQ7: Literal minus accumulator written to accumulator.
// RQ8: Literal subtract decoded by 11 110x.
// RQ9: Subtracts update carry, nibble and zero flags.
// RQ10: Literal subtract phases decode, read, process, write.
// RQ11: Carry is inverted borrow of subtraction.
// RQ12: Destination bit selects accumulator or register.
// RQ13: Register minus accumulator, prefix 00 0010.
// RQ14: Zero on zero result; nibble flag inverted borrow.
`timescale 1ns/1ps
module sse_exec
    import sse_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_SYS_RST,
    input wire logic i_ce,
    input wire logic [13:0] i_instr,
    input wire logic [7:0] i_file_rdata,
    input wire logic i_wake,
    output logic [7:0] o_acc,
    output logic o_carry,
    output logic o_nibble_borrow_flag,
    output logic o_zero,
    output logic o_sleep_entered_flag_n,
    output logic o_watchdog_expiry_flag_n,
    output logic o_watchdog_clear,
    output logic o_osc_halt,
    output logic [3:0] o_phase,
    output logic o_file_we,
    output logic [6:0] o_file_addr,
    output logic [7:0] o_file_wdata
);
    // ========================================
    // Phase sequencer
    sse_phase_t phase_q;
    sse_phase_t phase_d;
    logic halted_q;

    always_comb begin
        unique case (phase_q)
            SSE_Q1: phase_d = SSE_Q2;
            SSE_Q2: phase_d = SSE_Q3;
            SSE_Q3: phase_d = SSE_Q4;
            SSE_Q4: phase_d = SSE_Q1;
            default: phase_d = SSE_Q1;
        endcase
    end

    // ========================================
    // Decode
    wire logic is_sleep = (i_instr == SSE_OP_SLEEP); // [RQ1]
    wire logic is_lit_sub = (i_instr[13:9] == SSE_OP_LIT_SUB_TOP[5:1]); // [RQ8]
    wire logic is_file_sub = (i_instr[13:8] == SSE_OP_FILE_SUB_TOP); // [RQ13]
    wire logic dest_file = i_instr[7]; // [RQ12]

    // ========================================
    // Subtract datapath
    // Operand latched in Q2 so the file read path only needs to be valid then.
    logic [7:0] operand_q;
    logic [7:0] result_q;
    sse_alu_flags_t alu_q;
    wire logic [7:0] operand_src = is_lit_sub ? i_instr[7:0] : i_file_rdata; // [RQ10]
    wire logic [8:0] diff = {1'b0, operand_q} - {1'b0, o_acc}; // [RQ7] [RQ13]
    wire logic [4:0] low_diff = {1'b0, operand_q[3:0]} - {1'b0, o_acc[3:0]};
    wire sse_alu_flags_t alu_d = '{carry: ~diff[8], // [RQ11]
                                   nibble_borrow_flag: ~low_diff[4], // [RQ14]
                                   zero: (diff[7:0] == 8'h00)}; // [RQ14]
    wire logic is_sub = is_lit_sub | is_file_sub;
    wire logic at_q2 = (phase_q == SSE_Q2);
    wire logic at_q3 = (phase_q == SSE_Q3);
    wire logic at_q4 = (phase_q == SSE_Q4);
    wire logic run = i_ce & ~halted_q;
    wire logic wr_acc = at_q4 & is_sub & ~(is_file_sub & dest_file); // [RQ12]
    wire logic wr_file = at_q4 & is_file_sub & dest_file; // [RQ12]
    wire logic do_sleep = at_q3 & is_sleep; // [RQ6]
    wire sse_file_wr_t fwr_d = '{we: run & wr_file, addr: i_instr[6:0], data: result_q};

    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            phase_q <= SSE_Q1;
            operand_q <= SSE_ACC_RST;
            result_q <= SSE_ACC_RST;
            alu_q <= '0;
        end else if (run) begin
            phase_q <= phase_d;
            if (at_q2) begin
                operand_q <= operand_src; // [RQ10]
            end
            if (at_q3) begin
                result_q <= diff[7:0]; // [RQ10]
                alu_q <= alu_d;
            end
        end
    end

    // ========================================
    // Architectural state
    // Status flags change only at Q4 of a subtract; power-down never writes them.
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            o_acc <= SSE_ACC_RST;
            o_carry <= 1'b0;
            o_nibble_borrow_flag <= 1'b0;
            o_zero <= 1'b0;
        end else if (run && at_q4 && is_sub) begin
            {o_carry, o_nibble_borrow_flag, o_zero} <= alu_q; // [RQ9] [RQ3]
            if (wr_acc) begin
                o_acc <= result_q; // [RQ7]
            end
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            o_file_we <= 1'b0;
            o_file_addr <= 7'h00;
            o_file_wdata <= SSE_ACC_RST;
        end else if (i_ce) begin
            o_file_we <= fwr_d.we;
            o_file_addr <= fwr_d.addr;
            o_file_wdata <= fwr_d.data;
        end
    end

    // ========================================
    // Power-down
    // Wake-up handling belongs to the core; here a wake only lifts the halt.
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            o_sleep_entered_flag_n <= 1'b1;
            o_watchdog_expiry_flag_n <= 1'b1;
            o_watchdog_clear <= 1'b0;
            o_osc_halt <= 1'b0;
            halted_q <= 1'b0;
        end else if (i_ce) begin
            o_watchdog_clear <= run & do_sleep; // [RQ4]
            if (run && do_sleep) begin
                o_sleep_entered_flag_n <= 1'b0; // [RQ2]
                o_watchdog_expiry_flag_n <= 1'b1; // [RQ2]
                o_osc_halt <= 1'b1; // [RQ5]
                halted_q <= 1'b1; // [RQ5]
            end else if (halted_q && i_wake) begin
                o_osc_halt <= 1'b0;
                halted_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            o_phase <= SSE_Q1;
        end else if (i_ce) begin
            o_phase <= run ? phase_d : phase_q;
        end
    end
endmodule : sse_exec

/* sse_exec_props.sv */
// Checker on the ports of the execution block.
// Assumes a bind into sse_exec by port name.
`timescale 1ns/1ps
module sse_exec_props
    import sse_pkg::*;
(
    input wire logic I_CLK_SYS, I_SYS_RST, i_ce, i_wake, o_osc_halt, o_watchdog_clear,
    input wire logic o_carry, o_nibble_borrow_flag, o_zero, o_sleep_entered_flag_n,
    input wire logic o_watchdog_expiry_flag_n,
    input wire logic [13:0] i_instr,
    input wire logic [7:0] o_acc,
    input wire logic [3:0] o_phase
);
    // ====
    // Properties
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SYS_RST);
    wire logic run = i_ce && !o_osc_halt;
    wire logic slp = run && o_phase[2] && i_instr == SSE_OP_SLEEP;
    wire logic lit = run && o_phase[3] && i_instr[13:9] == 5'h1e;
    wire logic [2:0] f = {o_carry, o_nibble_borrow_flag, o_zero};
    wire logic [7:0] k = i_instr[7:0];
    a_phase_step: assert property (run && o_phase[0] |=> o_phase[1]) else $error("no step");
    a_sleep_flags: assert property (slp |=> o_osc_halt && !o_sleep_entered_flag_n
        && o_watchdog_expiry_flag_n) else $error("sleep flags");
    a_wdt_pulse: assert property (slp |=> o_watchdog_clear ##1 !o_watchdog_clear)
        else $error("clear pulse");
    a_sleep_keeps: assert property (slp |=> $stable({f, o_acc})) else $error("alu moved");
    a_halt_hold: assert property (o_osc_halt && !i_wake |=> $stable({o_osc_halt, o_phase}))
        else $error("halt lost");
    a_flags_hold: assert property (!(run && o_phase[3]) |=> $stable(f)) else $error("flags");
    a_lit_diff: assert property (lit |=> o_acc == 8'($past(k) - $past(o_acc))
        && o_carry == ($past(k) >= $past(o_acc))) else $error("difference");
    a_lit_zero: assert property (lit |=> o_zero == (o_acc == 8'h00)) else $error("zero");
endmodule : sse_exec_props
bind sse_exec sse_exec_props u_props (.*);

/* sse_pkg.sv */
// Constants and carrier types for the sleep and subtract execution block.
// Assumes a core that supplies a four-phase instruction cycle and a file register port.
package sse_pkg;
    // ========================================
    // Opcodes
    localparam logic [13:0] SSE_OP_SLEEP = 14'h0063;
    localparam logic [5:0] SSE_OP_LIT_SUB_TOP = 6'h3c;
    localparam logic [5:0] SSE_OP_FILE_SUB_TOP = 6'h02;
    // ========================================
    // Reset values
    localparam logic [7:0] SSE_ACC_RST = 8'h00;
    localparam logic [7:0] SSE_WDT_CLEAR = 8'h00;
    localparam logic [1:0] SSE_Q_RST = 2'h0;

    typedef enum logic [3:0] {
        SSE_Q1 = 4'b0001,
        SSE_Q2 = 4'b0010,
        SSE_Q3 = 4'b0100,
        SSE_Q4 = 4'b1000
    } sse_phase_t;

    typedef struct packed {
        logic carry;
        logic nibble_borrow_flag;
        logic zero;
    } sse_alu_flags_t;

    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } sse_file_wr_t;
endpackage : sse_pkg

/* tb_top.sv */
// Bench that plays the core around the execution block.
// Assumes the bound checker; inputs move 1 ns after each rising edge.
`timescale 1ns/1ps
module tb_top;
    import sse_pkg::*;
    logic I_CLK_SYS = 1'b0, I_SYS_RST = 1'b1, wake = 1'b0, ce = 1'b1;
    wire logic [3:0] ph;
    logic [13:0] ins = 14'h0000;
    logic [7:0] fd = 8'h00, w = 8'h00;
    logic [10:0] st;
    wire logic [10:0] alu;
    wire logic [15:0] fw;
    wire logic [3:0] pwr;
    int n_errors = 0, n_checks = 0, cyc = 0;
    sse_exec uut (.I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST), .i_ce(ce), .i_instr(ins),
        .i_file_rdata(fd), .i_wake(wake), .o_acc(alu[10:3]), .o_carry(alu[2]),
        .o_nibble_borrow_flag(alu[1]), .o_zero(alu[0]), .o_sleep_entered_flag_n(pwr[3]),
        .o_watchdog_expiry_flag_n(pwr[2]), .o_osc_halt(pwr[1]), .o_watchdog_clear(pwr[0]),
        .o_phase(ph), .o_file_we(fw[15]), .o_file_addr(fw[14:8]), .o_file_wdata(fw[7:0]));
    // ====
    // Clock, run limit, checks and scenarios
    always #4 I_CLK_SYS = ~I_CLK_SYS;
    always @(posedge I_CLK_SYS) if (++cyc == 400) begin
        n_errors++;
        tally_and_finish();
    end
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h %h", $time, got, exp);
        end
    endtask : chk
    task automatic sub(input logic [13:0] i, input logic [7:0] k);
        logic [7:0] r;
        logic dst;
        r = k - w;
        dst = i[13:12] == 2'h3 || !i[7];
        st = {dst ? r : w, k >= w, k[3:0] >= w[3:0], r == 8'h00};
        w = st[10:3];
        ins = i;
        fd = k;
        repeat (4) @(posedge I_CLK_SYS);
        #1 chk({5'h00, alu}, {5'h00, st});
        chk({fw[15], dst ? 15'h0000 : fw[14:0]}, {!dst, dst ? 15'h0000 : {i[6:0], r}});
        chk({12'h000, ph}, 16'h0001);
    endtask : sub
    task automatic reset_check();
        I_SYS_RST = 1'b1;
        @(posedge I_CLK_SYS);
        #1 I_SYS_RST = 1'b0;
        w = 8'h00;
        st = 11'h000;
        chk({5'h00, alu}, 16'h0000);
        chk({8'h00, pwr, ph}, 16'h00c1);
        chk(fw, 16'h0000);
    endtask : reset_check
    task automatic ce_hold();
        ce = 1'b0;
        repeat (3) @(posedge I_CLK_SYS);
        #1 chk({12'h000, ph}, 16'h0001);
        chk({5'h00, alu}, {5'h00, st});
        ce = 1'b1;
    endtask : ce_hold
    task automatic sleep_wake();
        ins = SSE_OP_SLEEP;
        repeat (3) @(posedge I_CLK_SYS);
        #1 chk({12'h000, pwr}, 16'h0007);
        chk({5'h00, alu}, {5'h00, st});
        chk({12'h000, ph}, 16'h0008);
        repeat (3) @(posedge I_CLK_SYS);
        #1 wake = 1'b1;
        chk({12'h000, pwr}, 16'h0006);
        chk({12'h000, ph}, 16'h0008);
        @(posedge I_CLK_SYS);
        #1 chk({15'h0000, pwr[1]}, 16'h0000);
    endtask : sleep_wake
    initial begin
        repeat (7) @(posedge I_CLK_SYS);
        #1 reset_check();
        sub(14'h3cff, 8'hff);
        sub(14'h3d02, 8'h02);
        sub(14'h0293, 8'h03);
        ce_hold();
        sub(14'h0211, 8'h11);
        sleep_wake();
        reset_check();
        tally_and_finish();
    end
endmodule : tb_top
